/* cbbt_pkg.sv */
package cbbt_pkg;
  // widths
  localparam int unsigned ADDR_W       = 16;                 // address bus width
  localparam int unsigned DATA_W       = 8;                  // data bus width
  // fixed addresses and reset values
  localparam logic [15:0] DUMMY_ADDR   = 16'hFFFF;           // idle read address
  localparam logic [15:0] RESET_PC     = 16'h0000;           // pc after reset
  localparam logic [7:0]  CCR_RESET    = 8'hD0;              // stop, x mask, i mask set
  localparam logic [7:0]  DIRECT_PAGE  = 8'h00;              // high byte of direct address
  // condition code bit positions
  localparam int unsigned CC_C         = 0;                  // carry
  localparam int unsigned CC_V         = 1;                  // overflow
  localparam int unsigned CC_Z         = 2;                  // zero
  localparam int unsigned CC_N         = 3;                  // negative
  // opcodes and opcode fields
  localparam logic [7:0]  OP_PAGE_Y    = 8'h18;              // y-index prefix
  localparam logic [3:0]  OP_BR_GROUP  = 4'h2;               // high nibble of branches
  localparam logic [3:0]  OP_BIT_LOW   = 4'h5;               // low nibble of bit test
  localparam logic [7:0]  OP_BIT_TEST_ACC_A_IDX  = 8'hA5;              // acc a indexed
  localparam logic [7:0]  OP_BIT_TEST_ACC_B_IDX  = 8'hE5;              // acc b indexed
  localparam int unsigned OP_ACC_BIT   = 6;                  // 0 acc a, 1 acc b
  localparam logic [7:0]  OP_BR_UGE    = 8'h24;              // branch_unsigned_ge
  localparam logic [7:0]  OP_BR_UGT    = 8'h22;              // branch_unsigned_gt
  localparam logic [7:0]  OP_BR_SGT    = 8'h2E;              // branch_signed_gt
  localparam logic [7:0]  OP_BR_SLE    = 8'h2F;              // branch_signed_le
  localparam logic [7:0]  OP_BR_ALW    = 8'h20;              // branch_always
  // bit test addressing modes, opcode bits 5:4
  localparam logic [1:0]  MODE_IMM     = 2'h0;               // immediate
  localparam logic [1:0]  MODE_DIR     = 2'h1;               // direct
  localparam logic [1:0]  MODE_IDX     = 2'h2;               // indexed
  localparam logic [1:0]  MODE_EXT     = 2'h3;               // extended
  // cycle counts
  localparam logic [2:0]  CYC_BRANCH   = 3'h3;               // any relative branch
  localparam logic [2:0]  CYC_IMM      = 3'h2;               // bit test immediate
  localparam logic [2:0]  CYC_DIR      = 3'h3;               // bit test direct
  localparam logic [2:0]  CYC_EXT      = 3'h4;               // bit test extended
  localparam logic [2:0]  CYC_IDX_X    = 3'h4;               // bit test x indexed
  localparam logic [2:0]  CYC_IDX_Y    = 3'h5;               // bit test y indexed

  // sign extension of a relative offset
  function automatic logic [15:0] sext8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction : sext8

  // flags after a bit test: n, z from result, v cleared, rest kept
  function automatic logic [7:0] bit_flags(input logic [7:0] cc, input logic [7:0] res);
    logic [7:0] r;
    r         = cc;
    r[CC_N]   = res[7];
    r[CC_Z]   = (res == 8'h00);
    r[CC_V]   = 1'b0;
    return r;
  endfunction : bit_flags
endpackage : cbbt_pkg

/* cbbt_cond.sv */
`timescale 1ns/10ps
`default_nettype none
module cbbt_cond (
  input  wire logic [3:0] i_sel,   // low nibble of branch opcode
  input  wire logic [7:0] i_ccr,   // condition_code_reg
  output logic            o_take   // branch condition true
);
  // flag taps
  wire logic c_f = i_ccr[cbbt_pkg::CC_C];   // carry
  wire logic v_f = i_ccr[cbbt_pkg::CC_V];   // overflow
  wire logic z_f = i_ccr[cbbt_pkg::CC_Z];   // zero
  wire logic n_f = i_ccr[cbbt_pkg::CC_N];   // negative
  wire logic nxv = n_f ^ v_f;               // signed less-than
  logic      base;                          // even-opcode condition

  // even opcode condition of each complementary pair
  always_comb begin
    unique case (i_sel[3:1])
      3'h0: base = 1'b1;             // always
      3'h1: base = ~(c_f | z_f);     // unsigned greater
      3'h2: base = ~c_f;             // unsigned ge, carry clear
      3'h3: base = ~z_f;             // not equal
      3'h4: base = ~v_f;             // no overflow
      3'h5: base = ~n_f;             // plus
      3'h6: base = ~nxv;             // signed ge
      3'h7: base = ~(z_f | nxv);     // signed greater
    endcase
  end

  // odd opcode is the complement
  assign o_take = base ^ i_sel[0];
endmodule : cbbt_cond
`default_nettype wire

/* cbbt_exec.sv */
// Summary of operation
// - unsigned ge branch 24 taken when carry clear
// - signed le 2F: Z or (N xor V)
// - full branch map 20..2F, pairs by bit0
// - taken target is opcode address+2+offset
// - branch reads opcode, offset, then FFFF
// - branches leave condition codes unchanged
// - non-arithmetic core updates keep the carry
// - bit test ANDs accumulator with operand
// - bit test writes neither accumulator nor memory
// - bit test opcodes for both accumulators
// - bit test cycle counts and bus addresses
`timescale 1ns/10ps
`default_nettype none
module cbbt_exec (
  input  wire logic        i_clk,        // 125 MHz core clock
  input  wire logic        i_reset,      // async reset, active high
  input  wire logic        i_ce,         // clock enable, freezes all state
  input  wire logic [7:0]  i_data,       // read data, valid in the same cycle
  input  wire logic [7:0]  i_acc_a,      // accumulator a of the core
  input  wire logic [7:0]  i_acc_b,      // accumulator b of the core
  input  wire logic [15:0] i_idx_x,      // index register x
  input  wire logic [15:0] i_idx_y,      // index register y
  input  wire logic        i_ccr_wr,     // core writes condition codes
  input  wire logic [7:0]  i_ccr_val,    // value written by the core
  input  wire logic        i_ccr_keep_c, // writer is inc/dec/ld/st/tst/clr/com class
  output logic             o_ccr_rdy,    // core write accepted this cycle
  output logic [15:0]      o_addr,       // bus address
  output logic             o_rw,         // 1 = read
  output logic [15:0]      o_pc,         // program counter
  output logic [7:0]       o_ccr,        // condition_code_reg
  output logic             o_done,       // instruction finished, pulse
  output logic             o_taken,      // branch taken, pulse with o_done
  output logic             o_unsup,      // opcode not handled here, pulse
  output logic [2:0]       o_cycles      // cycles of finished instruction
);
  typedef enum logic [2:0] {S_FETCH, S_PAGE, S_OPND, S_OPND2, S_BR_OFF, S_DUMMY, S_MEM}
    cbbt_state_t;

  cbbt_state_t state_ff;       // sequencer state
  cbbt_state_t nxt_state;      // next state
  logic [15:0] pc_ff;          // fetch pointer / pc
  logic [15:0] nxt_pc;         // next pc
  logic [7:0]  op_ff;          // current opcode
  logic        page_y_ff;      // y prefix seen
  logic [7:0]  hi_ff;          // first operand byte
  logic [7:0]  lo_ff;          // second operand byte
  logic [7:0]  rel_ff;         // branch offset
  logic [7:0]  ccr_ff;         // condition codes
  logic [7:0]  nxt_ccr;        // next condition codes
  logic [2:0]  cyc_ff;         // cycles so far
  logic        done_ff;        // done pulse
  logic        taken_ff;       // taken pulse
  logic        unsup_ff;       // unsupported pulse
  logic [2:0]  cycles_ff;      // length of last instruction
  logic        fin;            // this cycle ends an instruction
  logic        bad_op;         // this cycle rejects an opcode

  // opcode decoding
  wire logic       f_is_br  = (i_data[7:4] == cbbt_pkg::OP_BR_GROUP);
  wire logic       f_is_bit = i_data[7] && (i_data[3:0] == cbbt_pkg::OP_BIT_LOW);
  wire logic       f_is_pg  = (i_data == cbbt_pkg::OP_PAGE_Y);
  wire logic       p_ok     = (i_data == cbbt_pkg::OP_BIT_TEST_ACC_A_IDX) ||
                              (i_data == cbbt_pkg::OP_BIT_TEST_ACC_B_IDX);
  wire logic [1:0] mode     = op_ff[5:4];
  wire logic       is_br    = (op_ff[7:4] == cbbt_pkg::OP_BR_GROUP);
  wire logic [7:0] acc_sel  = op_ff[cbbt_pkg::OP_ACC_BIT] ? i_acc_b : i_acc_a; // selected_accumulator
  wire logic [7:0] and_res  = acc_sel & i_data;
  wire logic [15:0] idx_sel = page_y_ff ? i_idx_y : i_idx_x;
  wire logic [15:0] ea_idx  = idx_sel + {8'h00, hi_ff};
  wire logic [15:0] ea_dir  = {cbbt_pkg::DIRECT_PAGE, hi_ff};
  wire logic [15:0] ea_ext  = {hi_ff, lo_ff};
  wire logic [15:0] br_tgt  = pc_ff + cbbt_pkg::sext8(rel_ff);
  wire logic        take;                                                      // branch condition

  // branch condition on current codes
  cbbt_cond u_cond (
    .i_sel  (op_ff[3:0]),
    .i_ccr  (ccr_ff),
    .o_take (take)
  );

  // bus address per state, reads only
  assign o_rw      = 1'b1;
  assign o_addr    = (state_ff == S_DUMMY) ? cbbt_pkg::DUMMY_ADDR :
                     (state_ff != S_MEM)   ? pc_ff :
                     (mode == cbbt_pkg::MODE_DIR) ? ea_dir :
                     (mode == cbbt_pkg::MODE_EXT) ? ea_ext : ea_idx;
  assign o_ccr_rdy = (state_ff == S_FETCH);
  assign o_pc      = pc_ff;
  assign o_ccr     = ccr_ff;
  assign o_done    = done_ff;
  assign o_taken   = taken_ff;
  assign o_unsup   = unsup_ff;
  assign o_cycles  = cycles_ff;

  // sequencer next state, pc and flags
  always_comb begin
    nxt_state = state_ff;
    nxt_pc    = pc_ff;
    nxt_ccr   = ccr_ff;
    fin       = 1'b0;
    bad_op    = 1'b0;
    unique case (state_ff)
      S_FETCH: begin
        nxt_pc = pc_ff + 16'h0001;
        if (i_ccr_wr) begin
          // core update; carry held for the non-arithmetic class
          nxt_ccr = i_ccr_keep_c ? {i_ccr_val[7:1], ccr_ff[cbbt_pkg::CC_C]} : i_ccr_val;
        end
        if (f_is_pg) begin
          nxt_state = S_PAGE;
        end else if (f_is_br) begin
          nxt_state = S_BR_OFF;
        end else if (f_is_bit) begin
          nxt_state = S_OPND;
        end else begin
          bad_op = 1'b1;
        end
      end
      S_PAGE: begin
        nxt_pc    = pc_ff + 16'h0001;
        nxt_state = p_ok ? S_OPND : S_FETCH;
        bad_op    = ~p_ok;
      end
      S_OPND: begin
        nxt_pc = pc_ff + 16'h0001;
        unique case (mode)
          cbbt_pkg::MODE_IMM: begin
            nxt_ccr   = cbbt_pkg::bit_flags(ccr_ff, and_res);
            nxt_state = S_FETCH;
            fin       = 1'b1;
          end
          cbbt_pkg::MODE_DIR: nxt_state = S_MEM;
          cbbt_pkg::MODE_EXT: nxt_state = S_OPND2;
          cbbt_pkg::MODE_IDX: nxt_state = S_DUMMY;
        endcase
      end
      S_OPND2: begin
        nxt_pc    = pc_ff + 16'h0001;
        nxt_state = S_MEM;
      end
      S_BR_OFF: begin
        nxt_pc    = pc_ff + 16'h0001;
        nxt_state = S_DUMMY;
      end
      S_DUMMY: begin
        if (is_br) begin
          // pc already holds opcode address plus two; codes untouched
          nxt_pc    = take ? br_tgt : pc_ff;
          nxt_state = S_FETCH;
          fin       = 1'b1;
        end else begin
          nxt_state = S_MEM;
        end
      end
      S_MEM: begin
        nxt_ccr   = cbbt_pkg::bit_flags(ccr_ff, and_res);
        nxt_state = S_FETCH;
        fin       = 1'b1;
      end
    endcase
  end

  // state, pc and codes
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= S_FETCH;
      pc_ff    <= cbbt_pkg::RESET_PC;
      ccr_ff   <= cbbt_pkg::CCR_RESET;
    end else if (i_ce) begin
      state_ff <= nxt_state;
      pc_ff    <= nxt_pc;
      ccr_ff   <= nxt_ccr;
    end
  end

  // operand capture
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      op_ff     <= 8'h00;
      page_y_ff <= 1'b0;
      hi_ff     <= 8'h00;
      lo_ff     <= 8'h00;
      rel_ff    <= 8'h00;
    end else if (i_ce) begin
      if (state_ff == S_FETCH || state_ff == S_PAGE) begin
        op_ff <= i_data;
      end
      if (state_ff == S_FETCH) begin
        page_y_ff <= f_is_pg;
      end
      if (state_ff == S_OPND) begin
        hi_ff <= i_data;
      end
      if (state_ff == S_OPND2) begin
        lo_ff <= i_data;
      end
      if (state_ff == S_BR_OFF) begin
        rel_ff <= i_data;
      end
    end
  end

  // cycle count and status pulses
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cyc_ff    <= 3'h0;
      done_ff   <= 1'b0;
      taken_ff  <= 1'b0;
      unsup_ff  <= 1'b0;
      cycles_ff <= 3'h0;
    end else if (i_ce) begin
      cyc_ff   <= (state_ff == S_FETCH) ? 3'h1 : cyc_ff + 3'h1;
      done_ff  <= fin;
      taken_ff <= fin && is_br && take;
      unsup_ff <= bad_op;
      if (fin) begin
        cycles_ff <= cyc_ff + 3'h1;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  wire logic br_end  = (state_ff == S_DUMMY) && is_br && i_ce;
  wire logic bit_end = fin && !is_br && i_ce;
  wire logic [2:0] exp_cyc = (mode == cbbt_pkg::MODE_IMM) ? cbbt_pkg::CYC_IMM :
                             (mode == cbbt_pkg::MODE_DIR) ? cbbt_pkg::CYC_DIR :
                             (mode == cbbt_pkg::MODE_EXT) ? cbbt_pkg::CYC_EXT :
                             page_y_ff ? cbbt_pkg::CYC_IDX_Y : cbbt_pkg::CYC_IDX_X;

  property p_uge;
    br_end && op_ff == cbbt_pkg::OP_BR_UGE |=> o_taken == !$past(ccr_ff[cbbt_pkg::CC_C]);
  endproperty
  a_uge: assert property (p_uge) else $error("unsigned ge decision wrong");

  property p_sle;
    br_end && op_ff == cbbt_pkg::OP_BR_SLE |=> o_taken == ($past(ccr_ff[cbbt_pkg::CC_Z]) |
      ($past(ccr_ff[cbbt_pkg::CC_N]) ^ $past(ccr_ff[cbbt_pkg::CC_V])));
  endproperty
  a_sle: assert property (p_sle) else $error("signed le decision wrong");

  property p_map;
    br_end && (op_ff == cbbt_pkg::OP_BR_ALW || op_ff == cbbt_pkg::OP_BR_UGT ||
      op_ff == cbbt_pkg::OP_BR_SGT) |=> o_taken == ($past(op_ff) == cbbt_pkg::OP_BR_ALW ||
      ($past(op_ff) == cbbt_pkg::OP_BR_UGT &&
       !($past(ccr_ff[cbbt_pkg::CC_C]) | $past(ccr_ff[cbbt_pkg::CC_Z]))) ||
      ($past(op_ff) == cbbt_pkg::OP_BR_SGT && !($past(ccr_ff[cbbt_pkg::CC_Z]) |
       ($past(ccr_ff[cbbt_pkg::CC_N]) ^ $past(ccr_ff[cbbt_pkg::CC_V])))));
  endproperty
  a_map: assert property (p_map) else $error("branch map decision wrong");

  property p_target;
    br_end |=> o_pc == ($past(take) ? $past(pc_ff) + cbbt_pkg::sext8($past(rel_ff))
                                    : $past(pc_ff));
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  property p_br_seq;
    (state_ff == S_FETCH && f_is_br && i_ce) ##1 i_ce ##1 i_ce |->
      o_addr == cbbt_pkg::DUMMY_ADDR && $past(o_addr) == $past(o_addr, 2) + 16'h0001;
  endproperty
  a_br_seq: assert property (p_br_seq) else $error("branch bus sequence wrong");

  property p_br_cc;
    (state_ff == S_FETCH && f_is_br && i_ce && !i_ccr_wr) |=> $stable(o_ccr)[*3];
  endproperty
  a_br_cc: assert property (p_br_cc) else $error("branch changed codes");

  property p_keep_c;
    state_ff == S_FETCH && i_ce && i_ccr_wr && i_ccr_keep_c |=> $stable(o_ccr[cbbt_pkg::CC_C]);
  endproperty
  a_keep_c: assert property (p_keep_c) else $error("carry altered");

  property p_bit_cc;
    bit_end |=> o_ccr[cbbt_pkg::CC_N] == $past(and_res[7]) &&
      o_ccr[cbbt_pkg::CC_Z] == ($past(and_res) == 8'h00) && !o_ccr[cbbt_pkg::CC_V] &&
      $stable(o_ccr[cbbt_pkg::CC_C]);
  endproperty
  a_bit_cc: assert property (p_bit_cc) else $error("bit test flags wrong");

  property p_read_only;
    o_rw;
  endproperty
  a_read_only: assert property (p_read_only) else $error("write cycle issued");

  property p_bit_cyc;
    bit_end |=> o_cycles == $past(exp_cyc) && o_done;
  endproperty
  a_bit_cyc: assert property (p_bit_cyc) else $error("bit test cycle count wrong");

  property p_dir_addr;
    state_ff == S_MEM && mode == cbbt_pkg::MODE_DIR |-> o_addr[15:8] == 8'h00;
  endproperty
  a_dir_addr: assert property (p_dir_addr) else $error("direct address wrong");

  c_taken: cover property (br_end && take);
  c_not_taken: cover property (br_end && !take);
  c_idx_y: cover property (bit_end && page_y_ff);
  c_unsup: cover property (bad_op && i_ce);
endmodule : cbbt_exec
`default_nettype wire

/* cbbt_mem.sv */
`timescale 1ns/10ps
`default_nettype none
// memory seen by the core: one read per bus cycle, answered within the cycle
module cbbt_mem (
  input  wire logic [15:0] i_addr,  // bus address
  output logic      [7:0]  o_data   // read data, same cycle
);
  logic [7:0] mem [0:65535];        // byte store, loaded by the bench

  // unloaded bytes differ from their neighbours so stale data cannot pass
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hA5 ^ i[7:0];
    end
  end

  // combinational read, no wait states
  assign o_data = mem[i_addr];
endmodule : cbbt_mem
`default_nettype wire

/* cbbt_exec_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module cbbt_exec_tb;
  logic        i_clk, i_reset, i_ce;          // clock, reset, enable
  logic        i_ccr_wr, i_ccr_keep_c;        // core flag write
  logic [7:0]  i_data, i_acc_a, i_acc_b;      // bus data, accumulators
  logic [7:0]  i_ccr_val;                     // flag write value
  logic [15:0] i_idx_x, i_idx_y;              // index registers
  logic        o_ccr_rdy, o_rw, o_done;       // handshake, direction, done
  logic        o_taken, o_unsup;              // branch and skip pulses
  logic [15:0] o_addr, o_pc;                  // bus address, fetch pointer
  logic [7:0]  o_ccr;                         // flags
  logic [2:0]  o_cycles;                      // last instruction length
  int          num_errors, compares;          // tallies
  logic [15:0] pc_q;                          // next opcode address
  logic [7:0]  cc_q;                          // expected flags
  logic [7:0]  rr_t [4] = '{8'h05, 8'h7F, 8'hFC, 8'h03};  // offsets, net drift forward
  logic [7:0]  mv_t [10] = '{8'h81, 8'h3C, 8'h42, 8'hFF, 8'h01,
                             8'hC3, 8'h30, 8'hFF, 8'h24, 8'h0C};  // operands

  cbbt_exec dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_data(i_data),
    .i_acc_a(i_acc_a), .i_acc_b(i_acc_b), .i_idx_x(i_idx_x), .i_idx_y(i_idx_y),
    .i_ccr_wr(i_ccr_wr), .i_ccr_val(i_ccr_val), .i_ccr_keep_c(i_ccr_keep_c),
    .o_ccr_rdy(o_ccr_rdy), .o_addr(o_addr), .o_rw(o_rw), .o_pc(o_pc), .o_ccr(o_ccr),
    .o_done(o_done), .o_taken(o_taken), .o_unsup(o_unsup), .o_cycles(o_cycles));
  cbbt_mem mem_i (.i_addr(o_addr), .o_data(i_data));

  // free running clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // compare and tally
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // verdict and end of run
  task automatic results();
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // reference branch decision, pairs differ in bit 0
  function automatic logic cond(input logic [3:0] s, input logic [7:0] f);
    logic b;
    case (s[3:1])
      3'h0: b = 1'b1;
      3'h1: b = !(f[0] | f[2]);
      3'h2: b = !f[0];
      3'h3: b = !f[2];
      3'h4: b = !f[1];
      3'h5: b = !f[3];
      3'h6: b = !(f[3] ^ f[1]);
      default: b = !(f[2] | (f[3] ^ f[1]));
    endcase
    return b ^ s[0];
  endfunction : cond

  // hold reset 8 cycles, check reset state, release in fetch
  task automatic rst();
    i_reset = 1'b1;
    repeat (8) @(posedge i_clk);
    #1;
    chk(o_pc, cbbt_pkg::RESET_PC);
    chk(o_ccr, cbbt_pkg::CCR_RESET);
    chk(o_done, 1'b0);
    chk(o_cycles, 3'h0);
    chk(o_addr, cbbt_pkg::RESET_PC);
    i_reset = 1'b0;
    pc_q = cbbt_pkg::RESET_PC;
    cc_q = cbbt_pkg::CCR_RESET;
  endtask : rst

  // one instruction: load bytes, follow bus trace, judge the finish
  task automatic run(input logic [7:0] b[$], input logic [15:0] ea[$], input logic [15:0] epc,
                     input logic tk, input logic wr, input logic [7:0] wv, input logic kc,
                     input logic st);
    for (int k = 0; k < b.size(); k++) mem_i.mem[pc_q + k] = b[k];
    if (wr) cc_q = kc ? {wv[7:1], cc_q[0]} : wv;
    i_ccr_wr = wr;
    i_ccr_val = wv;
    i_ccr_keep_c = kc;
    for (int i = 0; i < ea.size(); i++) begin
      chk(o_addr, ea[i]);
      chk(o_rw, 1'b1);
      chk(o_ccr_rdy, i == 0);
      @(posedge i_clk);
      #1;
      if (i == 0) begin
        i_ccr_wr = 1'b0;
        // optional stall: the next address check proves the cycle held
        if (st) begin
          i_ce = 1'b0;
          repeat (2) @(posedge i_clk);
          #1;
          i_ce = 1'b1;
        end
      end
    end
    chk(o_done, 1'b1);
    chk(o_cycles, 16'(ea.size()));
    chk(o_taken, tk);
    chk(o_pc, epc);
    chk(o_addr, epc);
    chk(o_ccr, cc_q);
    pc_q = epc;
  endtask : run

  // relative branch with a flag write in its fetch cycle
  task automatic br(input logic [7:0] op, input logic [7:0] rr, input logic [7:0] cc,
                    input logic kc);
    logic        t;
    logic [15:0] tg;
    t = cond(op[3:0], kc ? {cc[7:1], cc_q[0]} : cc);
    tg = pc_q + 16'h0002 + (t ? {{8{rr[7]}}, rr} : 16'h0000);
    run('{op, rr}, '{pc_q, pc_q + 16'h0001, 16'hFFFF}, tg, t, 1'b1, cc, kc, 1'b0);
  endtask : br

  // bit test: md 0 imm, 1 dir, 2 ext, 3 x indexed, 4 y indexed
  task automatic bt(input logic ab, input int md, input logic [7:0] m, input logic st);
    logic [7:0]  op, r;
    logic [15:0] ea, p;
    p = pc_q;
    op = {1'b1, ab, (md == 0) ? 2'h0 : (md == 1) ? 2'h1 : (md == 2) ? 2'h3 : 2'h2, 4'h5};
    ea = (md == 1) ? 16'h00F0 : (md == 2) ? 16'h4321 :
         ((md == 3) ? i_idx_x : i_idx_y) + 16'h007F;
    r = (ab ? i_acc_b : i_acc_a) & m;
    cc_q = {cc_q[7:4], r[7], r == 8'h00, 1'b0, cc_q[0]};
    if (md != 0) mem_i.mem[ea] = m;
    case (md)
      0: run('{op, m}, '{p, p + 16'h0001}, p + 16'h0002, 1'b0, 1'b0, 8'h00, 1'b0, st);
      1: run('{op, 8'hF0}, '{p, p + 16'h0001, ea}, p + 16'h0002, 1'b0, 1'b0, 8'h00, 1'b0, st);
      2: run('{op, 8'h43, 8'h21}, '{p, p + 16'h0001, p + 16'h0002, ea}, p + 16'h0003,
             1'b0, 1'b0, 8'h00, 1'b0, st);
      3: run('{op, 8'h7F}, '{p, p + 16'h0001, 16'hFFFF, ea}, p + 16'h0002,
             1'b0, 1'b0, 8'h00, 1'b0, st);
      default: run('{8'h18, op, 8'h7F}, '{p, p + 16'h0001, p + 16'h0002, 16'hFFFF, ea},
                   p + 16'h0003, 1'b0, 1'b0, 8'h00, 1'b0, st);
    endcase
  endtask : bt

  // carry survives a keep-carry write, unsigned branches see the old carry
  task automatic carry_keep();
    br(8'h21, 8'h05, 8'h01, 1'b0);
    br(8'h24, 8'h05, 8'h0C, 1'b1);
    br(8'h25, 8'h05, 8'h00, 1'b1);
    // taken branch with no flag write, codes must stay put
    run('{8'h25, 8'h10}, '{pc_q, pc_q + 16'h0001, 16'hFFFF}, pc_q + 16'h0012,
        1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
  endtask : carry_keep

  // foreign opcodes: one plain byte, then a prefix with a foreign second byte
  task automatic skip_unsup();
    mem_i.mem[pc_q] = 8'h01;
    mem_i.mem[pc_q + 16'h0001] = 8'h18;
    mem_i.mem[pc_q + 16'h0002] = 8'h86;
    @(posedge i_clk);
    #1;
    chk(o_unsup, 1'b1);
    chk(o_done, 1'b0);
    chk(o_pc, pc_q + 16'h0001);
    @(posedge i_clk);
    #1;
    chk(o_unsup, 1'b0);
    chk(o_addr, pc_q + 16'h0002);
    @(posedge i_clk);
    #1;
    chk(o_unsup, 1'b1);
    chk(o_pc, pc_q + 16'h0003);
    chk(o_ccr, cc_q);
    pc_q = pc_q + 16'h0003;
  endtask : skip_unsup

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    results();
  end

  // main sequence
  initial begin
    num_errors = 0;
    compares = 0;
    i_ce = 1'b1;
    i_acc_a = 8'hC3;
    i_acc_b = 8'h3C;
    i_idx_x = 16'h5000;
    i_idx_y = 16'h6000;
    rst();
    carry_keep();
    skip_unsup();
    for (int j = 0; j < 10; j++) begin
      bt(j >= 5, j % 5, mv_t[j], j == 2);
    end
    for (int k = 0; k < 256; k++) begin
      br({4'h2, k[7:4]}, rr_t[k % 4], {4'hD, k[3:0]}, 1'b0);
    end
    br(8'h20, 8'h80, 8'hD5, 1'b0);
    rst();
    bt(1'b0, 0, 8'h81, 1'b0);
    results();
  end
endmodule : cbbt_exec_tb
`default_nettype wire
